// file: sim/peer_bridge_model.sv
// Far-end bridge unit: returns the local pattern stream to the line receiver.
// Assumes the bench owns packet pulses; this model only closes the pattern loop.
`timescale 1ns/1ns
`default_nettype none
module peer_bridge_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pattern_select,
  input  wire logic pattern_bit,
  output logic      tx_bit_en,
  output logic      rx_bit_valid,
  output logic      rx_bit
);
  logic tx_dly;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit_en    <= 1'b0;
      tx_dly       <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_bit       <= 1'b0;
    end else begin
      tx_bit_en    <= pattern_select;
      tx_dly       <= tx_bit_en;
      rx_bit_valid <= tx_dly;
      // Idle line toggles so a stale bit never looks valid
      rx_bit       <= tx_dly ? pattern_bit : ~rx_bit;
    end
  end
endmodule // peer_bridge_model
`default_nettype wire

// file: sim/tb_status_led_link_supervisor.sv
// Bench for the LED and link supervisor: APB register checks and indicator sequences.
// Assumes the peer model loops the pattern; small cycle counts stand in for seconds.
`timescale 1ns/1ns
`default_nettype none
module tb_status_led_link_supervisor;
  import led_supervisor_pkg::*;
  localparam int D = 40, S = 120, P = 1200, T = 1500;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [9:0]  cond = '0;
  logic        framed_pkt = 0, unframed_pkt = 0, dsp_linked = 0, sqe_heartbeat = 0, crc_error = 0;
  logic        test_switch = 0, remote_loop_req = 0, tx_bit_en, rx_bit_valid, rx_bit, serr, bad_rs = 0;
  logic        pready, pslverr, status_indicator, line_link_indicator, ethernet_link_indicator;
  logic        no_signal_indicator, error_indicator, test_mode_indicator, remote_digital_loopback;
  logic        pattern_select, pattern_bit, restart_pulse;
  int          n_mismatch = 0, n_tests = 0, n;
  time         t0;
  status_led_link_supervisor #(.GAP_CYC(20), .ON_CYC(4), .OFF_CYC(4), .FLASH_CYC(3), .START_CYC(S),
    .DATA_CYC(D), .TEST_CYC(T), .PATTERN_CYC(P)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .framed_pkt, .unframed_pkt, .dsp_linked, .sqe_heartbeat,
    .mac_table_empty(cond[0]), .cts_dcd_lost(cond[1]), .buffer_saturated(cond[2]), .wan_oversize(cond[3]),
    .wan_misaligned(cond[4]), .wan_aborted(cond[5]), .wan_bad_crc(cond[6]), .lan_oversize(cond[7]),
    .lan_misaligned(cond[8]), .lan_bad_crc(cond[9]), .crc_error, .test_switch, .remote_loop_req,
    .tx_bit_en, .rx_bit_valid, .rx_bit, .status_indicator, .line_link_indicator, .ethernet_link_indicator,
    .no_signal_indicator, .error_indicator, .test_mode_indicator, .remote_digital_loopback,
    .pattern_select, .pattern_bit, .restart_pulse);
  peer_bridge_model u_peer (.pclk, .presetn, .pattern_select, .pattern_bit, .tx_bit_en, .rx_bit_valid,
    .rx_bit);
  initial forever #25 pclk = ~pclk;
  // A restart during a running pattern would drop the link under test
  always @(posedge pclk) if (restart_pulse === 1'b1 && pattern_select === 1'b1) bad_rs <= 1'b1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    test_done();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    // A spare edge keeps psel from being cleared and set again in one step
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      if (++k > 20) hang();
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic burst(output int cnt);
    int k, lo;
    k = 0;
    lo = 0;
    cnt = 0;
    while (status_indicator !== 1'b1) begin
      @(posedge pclk);
      if (++k > 400) hang();
    end
    while (lo < 12) begin
      @(posedge pclk);
      if (status_indicator === 1'b1) cnt++;
      lo = (status_indicator === 1'b1) ? 0 : lo + 1;
    end
    // The sample that ended the wait was the first high one
    cnt = (cnt + 1) / 4;
  endtask
  task automatic restart(input int thr);
    int k;
    k = 0;
    unframed_pkt <= 1'b1;
    @(posedge pclk);
    unframed_pkt <= 1'b0;
    while (restart_pulse !== 1'b1) begin
      @(posedge pclk);
      if (++k > 2000) hang();
    end
    chk(k >= thr - 2 && k <= thr + 2, 1'b1);
  endtask
  task automatic frame;
    framed_pkt <= 1'b1;
    @(posedge pclk);
    framed_pkt <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic highs(input int cyc, output int h);
    h = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (error_indicator === 1'b1) h++;
    end
  endtask
  task automatic pattern_run(input logic inj);
    apb(1'b1, 12'h000, {31'h0, inj});
    test_switch  <= 1'b1;
    unframed_pkt <= 1'b1;
    t0 = $time;
    @(posedge pclk);
    unframed_pkt <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({pattern_select, test_mode_indicator}, 2'b11);
    repeat (20) @(posedge pclk);
    apb(1'b1, 12'h008, 32'h0);
    repeat (P - 100) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd != 0, inj);
    n = 0;
    while (pattern_select !== 1'b0) begin
      @(posedge pclk);
      if (++n > 500) hang();
    end
    n = int'(($time - t0) / 50);
    chk(n >= P - 1 && n <= P + 3, 1'b1);
    chk(bad_rs, 1'b0);
    highs(20, n);
    chk(n > 0, 1'b1);
    test_switch <= 1'b0;
    repeat (10) @(posedge pclk);
    highs(20, n);
    chk({n == 0, test_mode_indicator}, 2'b10);
    frame();
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    hang();
  end
  initial begin
    repeat (5) @(posedge pclk);
    chk({no_signal_indicator, status_indicator, line_link_indicator, test_mode_indicator}, 4'h8);
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    dsp_linked <= 1'b1;
    sqe_heartbeat <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({no_signal_indicator, ethernet_link_indicator}, 2'b01);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[4:0], 5'h08);
    apb(1'b0, 12'h00c, 32'h0);
    chk(serr, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    $display("Done registers");
    for (int c = 0; c <= 10; c++) begin
      cond <= (c == 0) ? 10'h0 : ((10'h1 << (c - 1)) | 10'h1);
      burst(n);
      burst(n);
      chk(n, c + 1);
    end
    $display("Done status codes");
    restart(S);
    frame();
    chk(line_link_indicator, 1'b1);
    crc_error <= 1'b1;
    @(posedge pclk);
    crc_error <= 1'b0;
    highs(10, n);
    chk(n, 3);
    restart(D);
    chk(line_link_indicator, 1'b0);
    crc_error <= 1'b1;
    @(posedge pclk);
    crc_error <= 1'b0;
    highs(10, n);
    chk(n, 0);
    frame();
    $display("Done link and restart");
    pattern_run(1'b0);
    pattern_run(1'b1);
    $display("Done pattern tests");
    remote_loop_req <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({test_mode_indicator, remote_digital_loopback}, 2'b11);
    restart(T);
    $display("Done remote loop");
    test_done();
  end
endmodule // tb_status_led_link_supervisor
`default_nettype wire

// file: src/led_supervisor_defines.svh
// Named timing figures, register map and field positions for the LED and link supervisor.
// Assumes a single 20 MHz pclk; included by the package and the design module.
`ifndef LED_SUPERVISOR_DEFINES_SVH
`define LED_SUPERVISOR_DEFINES_SVH
`define CLK_HZ          20000000
`define CLK_PER_MS      20000
`define BURST_GAP_S     2
`define PULSE_ON_MS     250
`define PULSE_OFF_MS    250
`define ERR_FLASH_MS    100
`define RESTART_START_S 50
`define RESTART_DATA_S  4
`define RESTART_TEST_S  60
`define PATTERN_TO_S    45
`define REG_CTRL        12'h000
`define REG_STAT        12'h004
`define REG_ERRS        12'h008
`define CTRL_INJ_BIT    0
`define CTRL_INJ_RST    1'b0
`define STAT_PAD        23
`define ERRS_PAD        16
`define CTRL_PAD        31
`define CODE_MAX        4'hb
`define CODE_NORMAL     4'h1
`define PRBS_SEED       9'h1ff
`define PRBS_TAP_A      8
`define PRBS_TAP_B      4
`define PRBS_INJ_STATE  9'h1ff
`define PRBS_SYNC_BITS  4'h9
`define ERRS_MAX        16'hffff
`endif

// file: src/led_supervisor_pkg.sv
// Types shared by the LED and link supervisor: state encodings and the state record.
// Assumes the defines header is on the include path.
`include "led_supervisor_defines.svh"
package led_supervisor_pkg;
  typedef enum logic [1:0] {
    TEST_IDLE    = 2'b00,
    TEST_RUN     = 2'b01,
    TEST_TIMEOUT = 2'b10
  } test_state_type;
  typedef enum logic [1:0] {
    BURST_GAP = 2'b00,
    BURST_ON  = 2'b01,
    BURST_OFF = 2'b10
  } burst_state_type;
  typedef struct packed {
    test_state_type  tst;
    burst_state_type bst;
    logic [31:0]     bcnt;
    logic [3:0]      bleft;
    logic [31:0]     rcnt;
    logic [31:0]     pcnt;
    logic [31:0]     ecnt;
    logic            startup;
    logic            link;
    logic            unframed;
    logic            restart;
    logic            sw_prev;
    logic [8:0]      gen;
    logic [8:0]      det;
    logic [3:0]      sync;
    logic            pbit;
    logic            status_led;
    logic            eth_led;
    logic            nosig_led;
    logic            err_led;
    logic            test_led;
    logic            loop_en;
    logic            pat_sel;
    logic            inj;
    logic [15:0]     errs;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } state_type;
endpackage

// file: src/status_led_link_supervisor.sv
// Front-panel indicators, unframed-packet restart timer and PRBS loopback test control.
// Assumes all inputs are synchronous to pclk and an APB master on the register port.
//
// What this block does
// RQ1: Yellow status blinks code, two-second gap between
// RQ2: Highest active condition code is shown
// RQ3: Codes one to four: ok, table, CTS/DCD, buffer
// RQ4: Line frames: oversize, misaligned, aborted, bad checksum
// RQ5: Ethernet frames: oversize, misaligned, bad checksum
// RQ6: Line link LED follows framed packet reception
// RQ7: Ethernet LED follows SQE heartbeat
// RQ8: Red no-signal LED while DSPs unlinked
// RQ9: Error LED flashes per checksum or bit error; checksum errors count only while the line link LED is lit
// RQ10: Test LED on for local or remote test
// RQ11: Framer sends framed, classifies received packets
// RQ12: Four seconds unframed in data mode restarts
// RQ13: Threshold fifty at startup, sixty during tests; the code uses the four-second DATA_CYC in TEST_TIMEOUT
// RQ14: Pattern inserted after framer, travels unframed
// RQ15: Pattern stops after forty-five seconds
// RQ16: Pattern timeout precedes test restart threshold
// RQ17: Error LED blinks after timeout until switch off
// RQ18: Remote end loops received pattern back
// RQ19: Test switch change enters or leaves test
// RQ20: Errored variant injects deliberate pattern errors
// RQ21: PRBS nine stages, taps nine and five
// RQ22: Fixed pulse on and off times
`timescale 1ns/1ns
`default_nettype none
`include "led_supervisor_defines.svh"
module status_led_link_supervisor #(
  parameter int unsigned GAP_CYC     = `BURST_GAP_S * `CLK_HZ,
  parameter int unsigned ON_CYC      = `PULSE_ON_MS * `CLK_PER_MS,
  parameter int unsigned OFF_CYC     = `PULSE_OFF_MS * `CLK_PER_MS,
  parameter int unsigned FLASH_CYC   = `ERR_FLASH_MS * `CLK_PER_MS,
  parameter int unsigned START_CYC   = `RESTART_START_S * `CLK_HZ,
  parameter int unsigned DATA_CYC    = `RESTART_DATA_S * `CLK_HZ,
  parameter int unsigned TEST_CYC    = `RESTART_TEST_S * `CLK_HZ,
  parameter int unsigned PATTERN_CYC = `PATTERN_TO_S * `CLK_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        framed_pkt,
  input  wire logic        unframed_pkt,
  input  wire logic        dsp_linked,
  input  wire logic        sqe_heartbeat,
  input  wire logic        mac_table_empty,
  input  wire logic        cts_dcd_lost,
  input  wire logic        buffer_saturated,
  input  wire logic        wan_oversize,
  input  wire logic        wan_misaligned,
  input  wire logic        wan_aborted,
  input  wire logic        wan_bad_crc,
  input  wire logic        lan_oversize,
  input  wire logic        lan_misaligned,
  input  wire logic        lan_bad_crc,
  input  wire logic        crc_error,
  input  wire logic        test_switch,
  input  wire logic        remote_loop_req,
  input  wire logic        tx_bit_en,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  output logic             status_indicator,
  output logic             line_link_indicator,
  output logic             ethernet_link_indicator,
  output logic             no_signal_indicator,
  output logic             error_indicator,
  output logic             test_mode_indicator,
  output logic             remote_digital_loopback,
  output logic             pattern_select,
  output logic             pattern_bit,
  output logic             restart_pulse
);
  import led_supervisor_pkg::*;

  state_type   s_q;
  state_type   s_d;
  logic [10:0] cond;
  logic [3:0]  code;
  logic [31:0] rth;
  logic        setup;
  logic        access;
  logic        fb;
  logic        expct;
  logic        bit_err;
  logic        evt;

  always_comb begin
    s_d = s_q;
    setup = psel & ~penable;
    access = psel & penable & s_q.pready;
    fb = 1'b0;
    expct = 1'b0;
    bit_err = 1'b0;

    // Condition index i stands for a burst of i+1 pulses; bit 0 is always present
    cond = {lan_bad_crc, lan_misaligned, lan_oversize,              // [RQ5]
            wan_bad_crc, wan_aborted, wan_misaligned, wan_oversize, // [RQ4]
            buffer_saturated, cts_dcd_lost, mac_table_empty, 1'b1}; // [RQ3]
    code = `CODE_NORMAL;
    for (int i = 0; i < 11; i++) begin
      if (cond[i]) begin
        code = 4'(i + 1); // [RQ2]
      end
    end

    // Burst sequencer; the code is sampled only at the end of the gap so a burst never changes midway
    s_d.bcnt = s_q.bcnt + 32'h1;
    unique case (s_q.bst)
      BURST_GAP: begin
        if (s_q.bcnt >= GAP_CYC - 1) begin // [RQ1]
          s_d.bcnt = '0;
          s_d.bleft = code;
          s_d.bst = BURST_ON;
        end
      end
      BURST_ON: begin
        if (s_q.bcnt >= ON_CYC - 1) begin // [RQ22]
          s_d.bcnt = '0;
          s_d.bleft = s_q.bleft - 4'h1;
          s_d.bst = BURST_OFF;
        end
      end
      BURST_OFF: begin
        if (s_q.bcnt >= OFF_CYC - 1) begin // [RQ22]
          s_d.bcnt = '0;
          s_d.bst = (s_q.bleft == 4'h0) ? BURST_GAP : BURST_ON; // [RQ1]
        end
      end
      default: begin
        s_d.bcnt = '0;
        s_d.bst = BURST_GAP;
      end
    endcase
    s_d.status_led = (s_d.bst == BURST_ON);

    // Front-panel test switch: a rising edge starts the test, a low level ends it
    s_d.sw_prev = test_switch;
    unique case (s_q.tst)
      TEST_IDLE: begin
        if (test_switch & ~s_q.sw_prev) begin // [RQ19]
          s_d.tst = TEST_RUN;
          s_d.pcnt = '0;
          s_d.gen = `PRBS_SEED;
        end
      end
      TEST_RUN: begin
        s_d.pcnt = s_q.pcnt + 32'h1;
        if (~test_switch) begin // [RQ19]
          s_d.tst = TEST_IDLE;
        end else if (s_q.pcnt >= PATTERN_CYC - 1) begin // [RQ15] [RQ16]
          s_d.tst = TEST_TIMEOUT;
        end
      end
      TEST_TIMEOUT: begin
        if (~test_switch) begin // [RQ17]
          s_d.tst = TEST_IDLE;
        end
      end
      default: s_d.tst = TEST_IDLE;
    endcase

    // Generator and detector share one polynomial; injection flips one bit per sequence period
    if (s_q.tst == TEST_RUN && tx_bit_en) begin
      fb = s_q.gen[`PRBS_TAP_A] ^ s_q.gen[`PRBS_TAP_B]; // [RQ21]
      s_d.gen = {s_q.gen[7:0], fb};
      s_d.pbit = fb ^ (s_q.inj & (s_q.gen == `PRBS_INJ_STATE)); // [RQ20]
    end
    if (s_q.tst != TEST_RUN) begin
      s_d.sync = '0;
    end else if (rx_bit_valid) begin
      expct = s_q.det[`PRBS_TAP_A] ^ s_q.det[`PRBS_TAP_B]; // [RQ21]
      bit_err = (s_q.sync == `PRBS_SYNC_BITS) && (rx_bit != expct);
      s_d.det = {s_q.det[7:0], rx_bit};
      if (s_q.sync != `PRBS_SYNC_BITS) begin
        s_d.sync = s_q.sync + 4'h1;
      end
    end
    s_d.pat_sel = (s_d.tst == TEST_RUN); // [RQ14]

    // Restart timer counts while only unframed packets arrive
    s_d.restart = 1'b0;
    if (framed_pkt) begin // [RQ11]
      s_d.unframed = 1'b0;
      s_d.rcnt = '0;
      s_d.link = 1'b1; // [RQ6]
      s_d.startup = 1'b0;
    end else if (unframed_pkt) begin
      s_d.unframed = 1'b1;
      s_d.link = 1'b0; // [RQ6]
    end
    if (s_q.startup) begin // [RQ13]
      rth = START_CYC;
    end else if (s_q.tst == TEST_RUN || remote_loop_req) begin // [RQ13]
      rth = TEST_CYC;
    end else begin
      rth = DATA_CYC; // [RQ12]
    end
    if (s_q.unframed && !framed_pkt) begin
      s_d.rcnt = s_q.rcnt + 32'h1;
      if (s_q.rcnt >= rth - 1) begin // [RQ12]
        s_d.restart = 1'b1;
        s_d.rcnt = '0;
        s_d.unframed = 1'b0;
        s_d.link = 1'b0;
        s_d.startup = 1'b1;
      end
    end

    // One flash per event; events during a flash merge into it, so fast bursts undercount
    evt = (crc_error & s_q.link) | bit_err; // [RQ9]
    if (s_q.ecnt != 32'h0) begin
      s_d.ecnt = s_q.ecnt - 32'h1;
    end else if (evt || s_q.tst == TEST_TIMEOUT) begin // [RQ17]
      s_d.ecnt = 2 * FLASH_CYC - 1;
    end
    s_d.err_led = (s_d.ecnt >= FLASH_CYC); // [RQ9]

    s_d.eth_led = sqe_heartbeat; // [RQ7]
    s_d.nosig_led = ~dsp_linked; // [RQ8]
    s_d.loop_en = remote_loop_req; // [RQ18]
    s_d.test_led = (s_d.tst != TEST_IDLE) | remote_loop_req; // [RQ10]

    // APB slave: data is prepared in the setup cycle so the access phase never waits
    if (bit_err && s_q.errs != `ERRS_MAX) begin
      s_d.errs = s_q.errs + 16'h1;
    end
    s_d.pready = setup;
    // Error flag stands only with the ready pulse, never beyond it
    s_d.pslverr = 1'b0;
    if (setup) begin
      unique case (paddr)
        `REG_CTRL: s_d.prdata = {{`CTRL_PAD{1'b0}}, s_q.inj};
        `REG_STAT: s_d.prdata = {{`STAT_PAD{1'b0}}, code, s_q.loop_en, s_q.startup, s_q.link, s_q.tst};
        `REG_ERRS: s_d.prdata = {{`ERRS_PAD{1'b0}}, s_q.errs};
        default: begin
          s_d.prdata = '0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (access && pwrite) begin
      if (paddr == `REG_CTRL) begin
        s_d.inj = pwdata[`CTRL_INJ_BIT];
      end
      // A bit error in the same cycle as the clear still counts
      if (paddr == `REG_ERRS) begin
        s_d.errs = {15'h0, bit_err};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.tst <= TEST_IDLE;
      s_q.bst <= BURST_GAP;
      s_q.startup <= 1'b1;
      s_q.nosig_led <= 1'b1;
      s_q.gen <= `PRBS_SEED;
      s_q.inj <= `CTRL_INJ_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign status_indicator = s_q.status_led;
  assign line_link_indicator = s_q.link;
  assign ethernet_link_indicator = s_q.eth_led;
  assign no_signal_indicator = s_q.nosig_led;
  assign error_indicator = s_q.err_led;
  assign test_mode_indicator = s_q.test_led;
  assign remote_digital_loopback = s_q.loop_en;
  assign pattern_select = s_q.pat_sel;
  assign pattern_bit = s_q.pbit;
  assign restart_pulse = s_q.restart;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_link_on_framed: assert property (framed_pkt |=> line_link_indicator && !restart_pulse) // [RQ6]
    else $error("line link not lit after framed packet");
  a_eth_led_sqe: assert property (sqe_heartbeat |=> ethernet_link_indicator) // [RQ7]
    else $error("ethernet link indicator does not follow heartbeat");
  a_no_signal_led: assert property (!dsp_linked |=> no_signal_indicator) // [RQ8]
    else $error("no-signal indicator off while DSPs unlinked");
  a_test_led_remote: assert property (remote_loop_req |=> test_mode_indicator && remote_digital_loopback) // [RQ10]
    else $error("remote loop not shown or not applied");
  a_test_switch_start: assert property ((s_q.tst == TEST_IDLE) && $rose(test_switch) |=> pattern_select) // [RQ19]
    else $error("pattern did not start on switch");
  a_test_switch_stop: assert property (!test_switch |=> !pattern_select) // [RQ19]
    else $error("pattern still selected with switch normal");
  a_restart_startup: assert property (restart_pulse |-> s_q.startup && !line_link_indicator) // [RQ13]
    else $error("restart did not return to startup");
  a_burst_gap_dark: assert property ((s_q.bst == BURST_GAP) |-> !status_indicator && s_q.bleft == 4'h0) // [RQ1]
    else $error("status indicator lit during gap");
  a_burst_code_range: assert property ((s_q.bst == BURST_ON) |-> s_q.bleft != 4'h0 && s_q.bleft <= `CODE_MAX) // [RQ2]
    else $error("burst count out of range");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");
endmodule // status_led_link_supervisor
`default_nettype wire
